// file: hw/gpcc_pkg.sv
/*
  Package for the graphics port command and control register block.
  Offsets, field positions, reset values and carrier structs.
  Assumes a plain register port and a single 100 MHz clock.
*/
package gpcc_pkg;

  localparam logic [7:0]  CMD_OFFSET     = 8'hA8;
  localparam logic [7:0]  CTRL_OFFSET    = 8'hB0;
  localparam logic [31:0] CMD_RESET      = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam logic [31:0] STAT_RATE_CAP  = 32'h0000_0007;

  localparam int CMD_SIDE_BAND_ENABLE_BIT   = 9;
  localparam int CMD_PORT_EN_BIT  = 8;
  localparam int CMD_HIGH_ADR_BIT = 5;
  localparam int CMD_FAST_WRITE_ENABLE_BIT    = 4;
  localparam int CMD_RATE_LSB     = 0;
  localparam int RATE_W           = 3;
  localparam int CTRL_TLB_EN_BIT  = 7;
  localparam int CTRL_QUAD_OVR_BIT = 0;

  localparam logic [2:0] RATE_1X = 3'h1;
  localparam logic [2:0] RATE_2X = 3'h2;
  localparam logic [2:0] RATE_4X = 3'h4;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } gpcc_req_t;

  typedef struct packed {
    logic       side_band_enable;
    logic       port_en;
    logic [2:0] rate;
  } gpcc_cmd_t;

  typedef struct packed {
    logic valid;
    logic sba;
    logic sba_first;
    logic sba_last;
    logic sync;
  } gpcc_op_t;

  typedef struct packed {
    logic        valid;
    logic [19:0] tag;
  } gpcc_xlat_t;

  typedef struct packed {
    logic        valid;
    logic [19:0] tag;
    logic        entry_valid;
  } gpcc_fill_t;

endpackage

// file: hw/gpcc_tlb.sv
/*
  Translation buffer tag store with LRU replacement and flush.
  Assumes lookups and fills come from the same clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module gpcc_tlb #(
  parameter int ENTRIES = 4
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              enable,
  input  wire logic              flush,
  input  wire gpcc_pkg::gpcc_xlat_t lookup,
  input  wire gpcc_pkg::gpcc_fill_t fill,
  output logic                   hit,
  output logic [ENTRIES-1:0]     valid_map
);
  localparam int IW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

  initial begin
    if (ENTRIES < 2 || ENTRIES > 16) begin
      $error("gpcc_tlb: ENTRIES out of range");
    end
  end

  logic [ENTRIES-1:0] vld;
  logic [ENTRIES-1:0] next_vld;
  logic [19:0]        tags [ENTRIES];
  logic [19:0]        next_tags [ENTRIES];
  logic [IW-1:0]      age [ENTRIES];
  logic [IW-1:0]      next_age [ENTRIES];
  logic [ENTRIES-1:0] match;
  logic [IW-1:0]      victim;
  logic [IW-1:0]      ref_age;
  logic               touch;
  logic [IW-1:0]      touch_idx;

  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++) begin : g_match
      assign match[g] = vld[g] && (tags[g] == lookup.tag);
    end
  endgenerate

  always_comb begin
    hit       = enable && lookup.valid && (|match);
    victim    = '0;
    touch_idx = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      if (age[i] == IW'(ENTRIES - 1)) begin
        victim = IW'(i);
      end
      if (match[i]) begin
        touch_idx = IW'(i);
      end
    end
    // Fills only while enabled; invalid entries are cached too
    touch = (hit) || (enable && fill.valid);
    if (!hit) begin
      touch_idx = victim;
    end
    ref_age = age[touch_idx];
    next_vld = vld;
    for (int i = 0; i < ENTRIES; i++) begin
      next_tags[i] = tags[i];
      next_age[i]  = age[i];
      if (touch) begin
        if (IW'(i) == touch_idx) begin
          next_age[i] = '0;
        end else if (age[i] < ref_age) begin
          next_age[i] = age[i] + IW'(1);
        end
      end
    end
    if (enable && fill.valid && !hit) begin
      next_vld[victim]  = fill.entry_valid || 1'b1;
      next_tags[victim] = fill.tag;
    end
    if (flush) begin
      next_vld = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      vld <= '0;
      for (int i = 0; i < ENTRIES; i++) begin
        tags[i] <= '0;
        age[i]  <= IW'(i);
      end
    end else begin
      vld <= next_vld;
      for (int i = 0; i < ENTRIES; i++) begin
        tags[i] <= next_tags[i];
        age[i]  <= next_age[i];
      end
    end
  end

  assign valid_map = vld;
endmodule
`default_nettype wire

// file: hw/gpcc_top.sv
/*
  Command and control registers of the target-side graphics port:
  side band and port enables, rate select, translation buffer control.
  Assumes a plain register port on clk and port operations decoded
  upstream into one-cycle strobes on the same clock.
*/
// The plain strobed port is this design's own decision.
// Operation
// - Side band commands accepted only while side band enable is set; the code still accepts the tail of one begun with it set after it clears
// - Port enabled: answer pipe requests; side band ones need its enable
// - Port disabled: ignore every operation, sync cycle included
// - Operations accepted while enabled finish after the port disables
// - Side band command partway in 1X when port disables still issues
// - High address support bit always reads zero
// - One-hot rate field selects 1X, 2X or 4x
// - With quad override set, rate bit 2 writes do nothing
// - Selected rate governs both data bus and side band bus
// - Translation buffer enabled: normal use for aperture translation
// - Translation buffer disabled: clear every entry's valid bit
// - Disabled buffer: aperture requests fetch entries from memory
// - Disabled buffer: fetched entries are not cached
// - Invalid fetched entries still cached, replacing least recent
// - Write buffer flushed whenever enable bit is set or cleared
// - Enable bit may change at any time, even mid access
// - Status 4x capability masked by the override control bit
`timescale 1ns/1ns
`default_nettype none
module gpcc_top #(
  parameter int TLB_ENTRIES = 4
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire gpcc_pkg::gpcc_req_t  req,
  output logic [31:0]               rdata,
  input  wire gpcc_pkg::gpcc_op_t   op,
  input  wire gpcc_pkg::gpcc_xlat_t xlat,
  input  wire gpcc_pkg::gpcc_fill_t fill,
  output logic                      op_accept,
  output logic                      sba_issue,
  output logic [2:0]                rate_sel,
  output logic                      sba_on,
  output logic                      tlb_hit,
  output logic                      mem_fetch,
  output logic                      gwb_flush,
  output logic                      rate_cap_4x
);

  initial begin
    if (TLB_ENTRIES < 2 || TLB_ENTRIES > 16) begin
      $error("gpcc_top: TLB_ENTRIES out of range");
    end
  end

  // Register state
  gpcc_pkg::gpcc_cmd_t cmd;
  gpcc_pkg::gpcc_cmd_t next_cmd;
  logic                tlb_en;
  logic                next_tlb_en;
  logic                quad_ovr;
  logic                next_quad_ovr;
  logic [31:0]         next_rdata;
  logic [31:0]         cmd_view;
  logic [31:0]         ctrl_view;
  logic                wr_cmd;
  logic                wr_ctrl;

  assign wr_cmd  = req.wr && (req.addr == gpcc_pkg::CMD_OFFSET);
  assign wr_ctrl = req.wr && (req.addr == gpcc_pkg::CTRL_OFFSET);

  always_comb begin
    cmd_view = '0;
    cmd_view[gpcc_pkg::CMD_SIDE_BAND_ENABLE_BIT]  = cmd.side_band_enable;
    cmd_view[gpcc_pkg::CMD_PORT_EN_BIT] = cmd.port_en;
    cmd_view[gpcc_pkg::CMD_HIGH_ADR_BIT] = 1'b0;
    cmd_view[gpcc_pkg::CMD_RATE_LSB +: gpcc_pkg::RATE_W] = cmd.rate;
    ctrl_view = '0;
    ctrl_view[gpcc_pkg::CTRL_TLB_EN_BIT]   = tlb_en;
    ctrl_view[gpcc_pkg::CTRL_QUAD_OVR_BIT] = quad_ovr;
  end

  always_comb begin
    next_cmd      = cmd;
    next_tlb_en   = tlb_en;
    next_quad_ovr = quad_ovr;
    if (wr_cmd) begin
      next_cmd.side_band_enable  = req.wdata[gpcc_pkg::CMD_SIDE_BAND_ENABLE_BIT];
      next_cmd.port_en = req.wdata[gpcc_pkg::CMD_PORT_EN_BIT];
      next_cmd.rate[1:0] = req.wdata[gpcc_pkg::CMD_RATE_LSB +: 2];
      if (!quad_ovr) begin
        next_cmd.rate[2] = req.wdata[gpcc_pkg::CMD_RATE_LSB + 2];
      end
    end
    if (wr_ctrl) begin
      next_tlb_en   = req.wdata[gpcc_pkg::CTRL_TLB_EN_BIT];
      next_quad_ovr = req.wdata[gpcc_pkg::CTRL_QUAD_OVR_BIT];
    end
    next_rdata = '0;
    if (req.rd) begin
      if (req.addr == gpcc_pkg::CMD_OFFSET) begin
        next_rdata = cmd_view;
      end else if (req.addr == gpcc_pkg::CTRL_OFFSET) begin
        next_rdata = ctrl_view;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmd      <= '0;
      tlb_en   <= 1'b0;
      quad_ovr <= 1'b0;
      rdata    <= gpcc_pkg::CMD_RESET;
    end else begin
      cmd      <= next_cmd;
      tlb_en   <= next_tlb_en;
      quad_ovr <= next_quad_ovr;
      rdata    <= next_rdata;
    end
  end

  // Port operation gating
  logic sba_busy;
  logic next_sba_busy;
  logic next_op_accept;
  logic next_sba_issue;
  logic new_ok;
  logic tail_ok;

  always_comb begin
    new_ok = cmd.port_en && op.valid &&
             (!op.sba || cmd.side_band_enable);
    // Command begun while enabled finishes regardless of port enable
    tail_ok = sba_busy && op.valid && op.sba;
    next_op_accept = new_ok || tail_ok;
    next_sba_issue = op.valid && op.sba && op.sba_last &&
                     ((new_ok && op.sba_first) || tail_ok);
    next_sba_busy = sba_busy;
    if (new_ok && op.sba && op.sba_first && !op.sba_last) begin
      next_sba_busy = 1'b1;
    end else if (next_sba_issue) begin
      next_sba_busy = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sba_busy  <= 1'b0;
      op_accept <= 1'b0;
      sba_issue <= 1'b0;
    end else begin
      sba_busy  <= next_sba_busy;
      op_accept <= next_op_accept;
      sba_issue <= next_sba_issue;
    end
  end

  // Rate, side band and capability outputs
  logic [2:0] next_rate_sel;
  logic       next_sba_on;
  logic       next_cap_4x;
  always_comb begin
    next_rate_sel = cmd.rate;
    next_sba_on   = cmd.side_band_enable && cmd.port_en;
    next_cap_4x   = gpcc_pkg::STAT_RATE_CAP[2] && !quad_ovr;
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rate_sel    <= '0;
      sba_on      <= 1'b0;
      rate_cap_4x <= 1'b0;
    end else begin
      rate_sel    <= next_rate_sel;
      sba_on      <= next_sba_on;
      rate_cap_4x <= next_cap_4x;
    end
  end

  // Translation buffer control
  logic                   tlb_hit_c;
  logic                   tlb_en_d;
  logic                   next_tlb_en_d;
  logic                   next_tlb_hit;
  logic                   next_mem_fetch;
  logic                   next_gwb_flush;
  logic [TLB_ENTRIES-1:0] tlb_valid;

  gpcc_tlb #(.ENTRIES(TLB_ENTRIES)) u_tlb (
    .clk       (clk),
    .rst_b     (rst_b),
    .enable    (tlb_en),
    .flush     (!tlb_en),
    .lookup    (xlat),
    .fill      (fill),
    .hit       (tlb_hit_c),
    .valid_map (tlb_valid)
  );

  always_comb begin
    next_tlb_en_d  = tlb_en;
    next_tlb_hit   = tlb_hit_c;
    next_mem_fetch = xlat.valid && !tlb_hit_c;
    next_gwb_flush = tlb_en != tlb_en_d;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tlb_en_d  <= 1'b0;
      tlb_hit   <= 1'b0;
      mem_fetch <= 1'b0;
      gwb_flush <= 1'b0;
    end else begin
      tlb_en_d  <= next_tlb_en_d;
      tlb_hit   <= next_tlb_hit;
      mem_fetch <= next_mem_fetch;
      gwb_flush <= next_gwb_flush;
    end
  end

  // Checks
  sequence s_sba_start;
    op.valid && op.sba && op.sba_first && !op.sba_last &&
    cmd.port_en && cmd.side_band_enable;
  endsequence
  sequence s_sba_end;
    op.valid && op.sba && op.sba_last;
  endsequence

  property p_sba_gate;
    @(posedge clk) disable iff (!rst_b)
      (op.valid && op.sba && !cmd.side_band_enable && !sba_busy) |=> !op_accept;
  endproperty
  a_sba_gate: assert property (p_sba_gate)
    else $error("side band accepted while disabled");

  property p_pipe_ok;
    @(posedge clk) disable iff (!rst_b)
      (op.valid && !op.sba && cmd.port_en) |=> op_accept;
  endproperty
  a_pipe_ok: assert property (p_pipe_ok)
    else $error("pipe request not accepted");

  property p_port_off;
    @(posedge clk) disable iff (!rst_b)
      (op.valid && !cmd.port_en && !sba_busy) |=> !op_accept;
  endproperty
  a_port_off: assert property (p_port_off)
    else $error("operation accepted while port disabled");

  property p_sba_finish;
    @(posedge clk) disable iff (!rst_b)
      s_sba_start ##1 (s_sba_end and !cmd.port_en) |=> sba_issue;
  endproperty
  a_sba_finish: assert property (p_sba_finish)
    else $error("side band command dropped on disable");

  property p_high_addr;
    @(posedge clk) disable iff (!rst_b)
      (req.rd && req.addr == gpcc_pkg::CMD_OFFSET) |=>
        !rdata[gpcc_pkg::CMD_HIGH_ADR_BIT];
  endproperty
  a_high_addr: assert property (p_high_addr)
    else $error("high address bit read as one");

  property p_rate_ovr;
    @(posedge clk) disable iff (!rst_b)
      (wr_cmd && quad_ovr) |=> (cmd.rate[2] == $past(cmd.rate[2]));
  endproperty
  a_rate_ovr: assert property (p_rate_ovr)
    else $error("rate bit 2 changed under override");

  property p_rate_out;
    @(posedge clk) disable iff (!rst_b)
      wr_cmd |=> ##1 rate_sel == $past(cmd.rate);
  endproperty
  a_rate_out: assert property (p_rate_out)
    else $error("rate select does not follow register");

  property p_flush;
    @(posedge clk) disable iff (!rst_b)
      (!tlb_en) |=> (tlb_valid == '0);
  endproperty
  a_flush: assert property (p_flush)
    else $error("buffer entries valid while disabled");

  property p_bypass;
    @(posedge clk) disable iff (!rst_b)
      (xlat.valid && !tlb_en) |=> (mem_fetch && !tlb_hit);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("disabled buffer did not bypass");

  property p_gwb;
    @(posedge clk) disable iff (!rst_b)
      (wr_ctrl && req.wdata[gpcc_pkg::CTRL_TLB_EN_BIT] != tlb_en)
        |=> ##1 gwb_flush;
  endproperty
  a_gwb: assert property (p_gwb)
    else $error("write buffer not flushed on enable change");

  property p_cap;
    @(posedge clk) disable iff (!rst_b)
      quad_ovr |=> !rate_cap_4x;
  endproperty
  a_cap: assert property (p_cap)
    else $error("4x capability not masked");

endmodule
`default_nettype wire

// file: verif/gpcc_master_model.sv
/*
  Behavioural graphics master: presents pipe, sync and side band
  operations, one or two cycles long, and reports its rate capability.
  Assumes the bench clock; requests change just after a rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module gpcc_master_model (
  input  wire logic              clk,
  output logic [2:0]             cap,
  output var gpcc_pkg::gpcc_op_t op
);
  // Master capability read by configuration software
  assign cap = gpcc_pkg::RATE_1X;
  initial op = '0;
  // Idle cycles carry a changing pattern beside a low valid
  task automatic idle();
    op <= '{1'b0, ~op.sba, ~op.sba_first, ~op.sba_last, ~op.sync};
  endtask
  // Kind: 0 pipe, 1 sync, 2 one-cycle side band, 3 two-cycle side band
  task automatic send(input int kind);
    @(posedge clk);
    op <= '{1'b1, kind > 1, kind > 1, kind == 2, kind == 1};
    if (kind == 3) begin
      @(posedge clk);
      op <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    end
    @(posedge clk);
    idle();
  endtask
endmodule
`default_nettype wire

// file: verif/gpcc_top_tb_top.sv
/*
  Self-checking bench for the command and control registers.
  Assumes the register port, the master model and a 100 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module gpcc_top_tb_top;
  localparam int         ENT    = 4;
  localparam logic [7:0] A_CMD  = gpcc_pkg::CMD_OFFSET;
  localparam logic [7:0] A_CTRL = gpcc_pkg::CTRL_OFFSET;
  logic                 clk;
  logic                 rst_b;
  gpcc_pkg::gpcc_req_t  req;
  gpcc_pkg::gpcc_op_t   op;
  gpcc_pkg::gpcc_xlat_t xlat;
  gpcc_pkg::gpcc_fill_t fill;
  logic [31:0]          rdata;
  logic [2:0]           rate_sel;
  logic [2:0]           cap;
  logic                 op_accept;
  logic                 sba_issue;
  logic                 sba_on;
  logic                 tlb_hit;
  logic                 mem_fetch;
  logic                 gwb_flush;
  logic                 rate_cap_4x;
  logic [31:0]          cmd_m;
  logic [31:0]          ctrl_m;
  logic [19:0]          base;
  int                   q[$];
  int                   bad_count;
  int                   n_tests;

  gpcc_top #(.TLB_ENTRIES(ENT)) i_dut (
    .clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata), .op(op),
    .xlat(xlat), .fill(fill), .op_accept(op_accept),
    .sba_issue(sba_issue), .rate_sel(rate_sel), .sba_on(sba_on),
    .tlb_hit(tlb_hit), .mem_fetch(mem_fetch), .gwb_flush(gwb_flush),
    .rate_cap_4x(rate_cap_4x));
  gpcc_master_model i_master (.clk(clk), .cap(cap), .op(op));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Register write, with the model of both registers
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic old;
    @(posedge clk);
    req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    req <= '{~a, ~v, 1'b0, 1'b0};
    old = cmd_m[2];
    if (a == A_CMD) begin
      cmd_m = v & 32'h0000_0307;
      if (ctrl_m[0]) cmd_m[2] = old;
    end else if (a == A_CTRL) begin
      ctrl_m = v & 32'h0000_0081;
      if (!ctrl_m[7]) q.delete();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    req <= '{a, ~exp, 1'b0, 1'b1};
    @(posedge clk);
    req <= '{~a, exp, 1'b0, 1'b0};
    #1 chk(rdata, exp);
  endtask

  // Control write; a write buffer flush pulse follows a changed enable
  task automatic wctl(input logic [31:0] v);
    logic ch;
    ch = ctrl_m[7] ^ v[7];
    wr(A_CTRL, v);
    @(posedge clk);
    #1 chk(gwb_flush, ch);
    @(posedge clk);
    #1 chk(gwb_flush, 1'b0);
  endtask

  task automatic levels();
    repeat (3) @(posedge clk);
    #1 chk(rate_sel, cmd_m[2:0]);
    chk(sba_on, cmd_m[9] & cmd_m[8]);
    chk(rate_cap_4x, !ctrl_m[0]);
  endtask

  task automatic opx(input int kind, input logic exp);
    i_master.send(kind);
    #1 chk((kind > 1) ? sba_issue : op_accept, exp);
  endtask

  task automatic fl(input logic [19:0] t, input logic ev);
    @(posedge clk);
    fill <= '{1'b1, t, ev};
    @(posedge clk);
    fill <= '{1'b0, ~t, ~ev};
    if (ctrl_m[7]) q.push_back(int'(t));
    if (q.size() > ENT) void'(q.pop_front());
  endtask

  task automatic look(input logic [19:0] t);
    logic h;
    @(posedge clk);
    xlat <= '{1'b1, t};
    @(posedge clk);
    xlat <= '{1'b0, ~t};
    h = 1'b0;
    foreach (q[i]) if (q[i] == int'(t)) h = 1'b1;
    #1 chk(tlb_hit, h);
    chk(mem_fetch, !h);
  endtask

  initial begin
    #900_000;
    bad_count++;
    end_sim();
  end

  initial begin
    rst_b = 1'b0;
    req = '0;
    xlat = '0;
    fill = '0;
    cmd_m = '0;
    ctrl_m = '0;
    bad_count = 0;
    n_tests = 0;
    void'($urandom(32'hd6f55d7d));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd(A_CMD, 32'h0000_0000);
    rd(A_CTRL, 32'h0000_0000);
    levels();
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      wr(A_CMD, ($urandom & 32'hFFFF_FEE8) | (32'h1 << k));
      wr(8'hAC, $urandom);
      rd(A_CMD, cmd_m);
      rd(8'hAC, 32'h0000_0000);
      levels();
    end
    wctl(($urandom & 32'hFFFF_FF7E) | 32'h0000_0080);
    rd(A_CTRL, ctrl_m);
    wr(A_CMD, 32'h0000_0304);
    wctl(32'h0000_0081);
    levels();
    wr(A_CMD, 32'h0000_0301);
    rd(A_CMD, cmd_m);
    wr(A_CMD, 32'h0000_0302);
    levels();
    wctl(32'h0000_0080);
    levels();
    $display("test registers done");
    base = 20'($urandom & 32'h000F_FFF0);
    for (int k = 0; k < 5; k++) fl(base + 20'(k), k != 2);
    look(base);
    look(base + 20'h2);
    look(base + 20'h4);
    wctl(32'h0000_0000);
    look(base + 20'h4);
    fl(base + 20'h7, 1'b1);
    look(base + 20'h7);
    wctl(32'h0000_0080);
    look(base + 20'h4);
    $display("test translation done");
    for (int e = 0; e < 4; e++) begin
      wr(A_CMD, (32'(3 - e) << 8) | 32'(cap));
      levels();
      opx(0, cmd_m[8]);
      opx(1, cmd_m[8]);
      opx(2, cmd_m[8] & cmd_m[9]);
      opx(3, cmd_m[8] & cmd_m[9]);
    end
    wr(A_CMD, 32'h0000_0300 | 32'(cap));
    fork
      i_master.send(0);
      wr(A_CMD, 32'h0000_0200 | 32'(cap));
    join
    #1 chk(op_accept, 1'b1);
    wr(A_CMD, 32'h0000_0300 | 32'(cap));
    fork
      i_master.send(3);
      wr(A_CMD, 32'h0000_0200 | 32'(cap));
    join
    #1 chk(sba_issue, 1'b1);
    opx(2, 1'b0);
    $display("test operations done");
    end_sim();
  end
endmodule
`default_nettype wire
